/* File: hw/seep_bus_if.sv */
interface seep_bus_if;
  logic scl_o;
  logic sda_m_o;
  logic sda_m_oe;
  logic sda_d_o;
  logic sda_d_oe;
  wire sda = ~((sda_m_oe & ~sda_m_o) | (sda_d_oe & ~sda_d_o));
  wire scl = scl_o;
  modport master (output scl_o, sda_m_o, sda_m_oe, input sda);
  modport device (input scl, sda, output sda_d_o, sda_d_oe);
endinterface

/* File: hw/seep_consts.svh */
`ifndef SEEP_CONSTS_SVH
`define SEEP_CONSTS_SVH
// Type code value is arbitrary
`define SEEP_TYPE_CODE 4'h6
`define SEEP_DIR_READ 1'b1
`define SEEP_DIR_WRITE 1'b0
`define SEEP_ADDR_LAST 7'h7f
`define SEEP_ADDR_ZERO 7'h00
`define SEEP_BIT_LAST 4'h7
`define SEEP_BIT_ACK 4'h8
`define SEEP_BIT_PRE 4'hf
`define SEEP_CLK_MHZ 50
`define SEEP_TWC_US 5000
`define SEEP_TWC_CYC (`SEEP_TWC_US * `SEEP_CLK_MHZ)
`define SEEP_HDIV 4
`endif

/* File: hw/seep_device.sv */
// Function
// - Idle only while both lines high
// - SDA fall with SCL high starts
// - SDA rise with SCL high stops
// - Change SDA only while SCL low
// - Receiver acknowledges each byte on ninth clock
// - No acknowledge during programming cycle
// - Acknowledge held low through clock high
// - Master no-ack ends read; release SDA
// - Upper four bits match type code
// - Control LSB one reads, zero writes
// - Byte write: control, address, data acked
// - Stop after data starts timed programming
// - Buffer up to eight bytes, commit at stop
// - Low pointer bits advance, oldest overwritten
// - Page writes wrap within one page
// - Polling write control acked once idle
// - Write-protect high inhibits all programming
// - Current read uses last address plus one
// - Matched read acks, then shifts byte out
// - Repeated start after address sets pointer
// - Pointer advances after each byte sent; master ack gets next byte
// - Write-protect low allows full range
`include "seep_consts.svh"
module seep_device
  import seep_pkg::*;
#(
  parameter int TWC_CYC = `SEEP_TWC_CYC,
  parameter int PAGE = 8,
  parameter int DEPTH = 128,
  // Type code value is arbitrary
  parameter logic [3:0] TYPE_CODE = `SEEP_TYPE_CODE
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic wp,
  seep_bus_if.device bus,
  output logic busy
);

  localparam int PW = $clog2(PAGE);
  localparam int AW = $clog2(DEPTH);
  logic scl_s, sda_s, scl_d_r, sda_d_r, wp_s;
  // Both lines pass equal delay, so start and stop order survives
  seep_sync u_scl (.clk(clk), .reset(reset), .d(bus.scl), .q(scl_s));
  seep_sync u_sda (.clk(clk), .reset(reset), .d(bus.sda), .q(sda_s));
  // Protect level comes from a pin, outside the clock domain
  seep_sync u_wp (.clk(clk), .reset(reset), .d(wp), .q(wp_s));

  logic [7:0] mem_r [DEPTH];
  logic [7:0] page_r [PAGE];
  logic [PAGE-1:0] pvalid_r;
  seep_state_t st_r;
  logic [3:0] bit_r;
  logic [7:0] sh_r;
  logic [AW-1:0] ptr_r;
  logic [AW-1:0] wbase_r;
  logic ack_r, dout_r, sda_oe_r, dir_r, wrpend_r, busy_r;
  logic [31:0] twc_r;

  function automatic logic [PW-1:0] slot_of(input logic [AW-1:0] a);
    return a[PW-1:0];
  endfunction

  always_ff @(posedge clk) begin
    if (reset) begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_d_r <= scl_s;
      sda_d_r <= sda_s;
    end
  end

  wire scl_rise = scl_s & ~scl_d_r;
  wire scl_fall = ~scl_s & scl_d_r;
  wire start_c = scl_s & scl_d_r & sda_d_r & ~sda_s;
  wire stop_c = scl_s & scl_d_r & ~sda_d_r & sda_s;
  wire prog = busy_r;
  wire [7:0] rx_byte = {sh_r[6:0], sda_s};
  wire ctrl_ok = (rx_byte[7:4] == TYPE_CODE) && !prog;
  wire is_rd = (rx_byte[0] == `SEEP_DIR_READ);
  wire last_bit = (bit_r == `SEEP_BIT_LAST);
  wire ack_bit = (bit_r == `SEEP_BIT_ACK);
  wire [7:0] rd_word = mem_r[ptr_r];
  // Next bit out, one ahead of the count that the fall advances
  wire rd_next = rd_word[3'(`SEEP_BIT_LAST - bit_r - 4'h1)];
  wire [AW-1:0] ptr_inc = (ptr_r == AW'(`SEEP_ADDR_LAST)) ?
    AW'(`SEEP_ADDR_ZERO) : ptr_r + AW'(1);
  wire [AW-1:0] page_inc = {ptr_r[AW-1:PW], ptr_r[PW-1:0] + PW'(1)};
  // Commit only if data arrived and protection is off
  wire commit = stop_c && wrpend_r && !wp_s;
  assign busy = busy_r;
  assign bus.sda_d_o = dout_r;
  assign bus.sda_d_oe = sda_oe_r;

  always_ff @(posedge clk) begin
    if (reset) begin
      st_r <= SEEP_IDLE;
      bit_r <= 4'h0;
      sh_r <= 8'h00;
      ptr_r <= AW'(`SEEP_ADDR_ZERO);
      wbase_r <= AW'(`SEEP_ADDR_ZERO);
      ack_r <= 1'b0;
      dir_r <= 1'b0;
      dout_r <= 1'b1;
      sda_oe_r <= 1'b0;
      wrpend_r <= 1'b0;
      pvalid_r <= '0;
    end else if (start_c) begin
      st_r <= SEEP_CTRL;
      bit_r <= `SEEP_BIT_PRE; // Start's own clock fall brings it to 0
      sda_oe_r <= 1'b0;
      wrpend_r <= 1'b0; // Repeated start skips programming
      pvalid_r <= '0;
    end else if (stop_c) begin
      st_r <= SEEP_IDLE;
      sda_oe_r <= 1'b0;
      wrpend_r <= 1'b0;
      pvalid_r <= '0;
    end else if (st_r != SEEP_IDLE && st_r != SEEP_SKIP) begin
      if (scl_rise) begin // Sample at clock rise
        if (ack_bit) begin
          ack_r <= ~sda_s; // Master ack during reads
        end else begin
          sh_r <= rx_byte;
        end
        if (last_bit && st_r != SEEP_RDATA) begin
          unique case (st_r)
            SEEP_CTRL: begin
              ack_r <= ctrl_ok;
              dir_r <= is_rd;
            end
            SEEP_WADDR: begin
              ptr_r <= rx_byte[AW-1:0];
              wbase_r <= rx_byte[AW-1:0];
              ack_r <= 1'b1;
            end
            SEEP_WDATA: begin
              page_r[slot_of(ptr_r)] <= rx_byte;
              pvalid_r[slot_of(ptr_r)] <= 1'b1;
              ptr_r <= page_inc;
              wrpend_r <= 1'b1;
              ack_r <= 1'b1;
            end
            default: ack_r <= 1'b0;
          endcase
        end
      end else if (scl_fall) begin // Drive only after clock fall
        bit_r <= ack_bit ? 4'h0 : bit_r + 4'h1;
        if (last_bit && st_r != SEEP_RDATA) begin
          sda_oe_r <= ack_r;
          dout_r <= 1'b0;
          if (!ack_r) st_r <= SEEP_SKIP;
        end else if (ack_bit && st_r != SEEP_RDATA) begin
          sda_oe_r <= 1'b0;
          if (st_r == SEEP_CTRL) begin
            st_r <= dir_r ? SEEP_RDATA : SEEP_WADDR;
            if (dir_r) begin
              sda_oe_r <= 1'b1;
              dout_r <= rd_word[7];
            end
          end else begin
            st_r <= SEEP_WDATA;
          end
        end else if (st_r == SEEP_RDATA) begin
          if (last_bit) begin
            sda_oe_r <= 1'b0; // Free line for master ack
            ptr_r <= ptr_inc;
          end else if (ack_bit) begin
            sda_oe_r <= ack_r; // No-ack releases line
            dout_r <= rd_word[7];
            if (!ack_r) st_r <= SEEP_SKIP;
          end else begin
            dout_r <= rd_next;
          end
        end
      end
    end
  end

  // Programming timer; polls see no ack until it expires
  // Busy comes from a flop, not from the counter compare
  always_ff @(posedge clk) begin
    if (reset) begin
      twc_r <= 32'd0;
      busy_r <= 1'b0;
    end else if (commit) begin
      twc_r <= 32'(TWC_CYC);
      busy_r <= 1'b1;
    end else if (prog) begin
      twc_r <= twc_r - 32'd1;
      if (twc_r == 32'd1) busy_r <= 1'b0;
    end
  end

  // Array write of buffered page, within one page only
  // One process per word keeps every write index constant
  genvar g;
  for (g = 0; g < DEPTH; g++) begin : g_commit
    localparam logic [AW-1:0] WA = AW'(g);
    always_ff @(posedge clk) begin
      if (commit && pvalid_r[slot_of(WA)] &&
          wbase_r[AW-1:PW] == WA[AW-1:PW]) begin
        mem_r[g] <= page_r[slot_of(WA)];
      end
    end
  end
endmodule

/* File: hw/seep_master.sv */
`include "seep_consts.svh"
module seep_master
  import seep_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic req,
  input wire logic [8:0] tx_word,
  input wire logic tx_start,
  input wire logic tx_stop,
  output logic done,
  output logic [8:0] rx_word,
  seep_bus_if.master bus
);
  // Word: bits 8..1 data (MSB first), bit 0 ack slot; 1 releases line
  seep_mstate_t st_r;
  logic [2:0] div_r;
  logic [1:0] ph_r;
  logic [3:0] n_r;
  logic [8:0] sh_r;
  logic stop_r, scl_r, pull_r;
  logic sda_s;
  seep_sync u_sda (.clk(clk), .reset(reset), .d(bus.sda), .q(sda_s));
  wire tick = (div_r == 3'(`SEEP_HDIV - 1));
  assign bus.scl_o = scl_r;
  assign bus.sda_m_o = 1'b0;
  assign bus.sda_m_oe = pull_r;
  always_ff @(posedge clk) begin
    if (reset) begin
      st_r <= SEEP_M_IDLE;
      div_r <= 3'h0;
      ph_r <= 2'h0;
      n_r <= 4'h0;
      sh_r <= 9'h000;
      stop_r <= 1'b0;
      scl_r <= 1'b1;
      pull_r <= 1'b0;
      done <= 1'b0;
      rx_word <= 9'h000;
    end else begin
      done <= 1'b0;
      div_r <= tick ? 3'h0 : div_r + 3'h1;
      unique case (st_r)
        SEEP_M_IDLE: if (req) begin
          sh_r <= tx_word;
          stop_r <= tx_stop;
          ph_r <= 2'h0;
          n_r <= 4'h0;
          st_r <= tx_start ? SEEP_M_START : SEEP_M_BIT;
        end
        SEEP_M_START: if (tick) begin
          ph_r <= ph_r + 2'h1;
          unique case (ph_r)
            2'h0: pull_r <= 1'b0;
            2'h1: scl_r <= 1'b1;
            2'h2: pull_r <= 1'b1;
            2'h3: begin
              scl_r <= 1'b0;
              st_r <= SEEP_M_BIT;
            end
          endcase
        end
        SEEP_M_BIT: if (tick) begin
          ph_r <= ph_r + 2'h1;
          unique case (ph_r)
            2'h0: pull_r <= ~sh_r[8];
            2'h1: scl_r <= 1'b1;
            2'h2: rx_word <= {rx_word[7:0], sda_s};
            2'h3: begin
              scl_r <= 1'b0;
              sh_r <= {sh_r[7:0], 1'b1};
              n_r <= n_r + 4'h1;
              if (n_r == `SEEP_BIT_ACK) begin
                st_r <= stop_r ? SEEP_M_STOP : SEEP_M_DONE;
              end
            end
          endcase
        end
        SEEP_M_STOP: if (tick) begin
          ph_r <= ph_r + 2'h1;
          unique case (ph_r)
            2'h0: pull_r <= 1'b1;
            2'h1: scl_r <= 1'b1;
            2'h2: pull_r <= 1'b0;
            2'h3: st_r <= SEEP_M_DONE;
          endcase
        end
        SEEP_M_DONE: begin
          done <= 1'b1;
          st_r <= SEEP_M_IDLE;
        end
        default: st_r <= SEEP_M_IDLE;
      endcase
    end
  end
endmodule

/* File: hw/seep_pkg.sv */
package seep_pkg;
  typedef enum logic [2:0] {
    SEEP_IDLE = 3'b000,
    SEEP_CTRL = 3'b001,
    SEEP_WADDR = 3'b010,
    SEEP_WDATA = 3'b011,
    SEEP_RDATA = 3'b100,
    SEEP_SKIP = 3'b101
  } seep_state_t;
  typedef enum logic [2:0] {
    SEEP_M_IDLE = 3'b000,
    SEEP_M_START = 3'b001,
    SEEP_M_BIT = 3'b010,
    SEEP_M_STOP = 3'b011,
    SEEP_M_DONE = 3'b100
  } seep_mstate_t;
endpackage

/* File: hw/seep_sync.sv */
module seep_sync (
  input wire logic clk,
  input wire logic reset,
  input wire logic d,
  output logic q
);
  logic s1_r;
  always_ff @(posedge clk) begin
    if (reset) begin
      s1_r <= 1'b1;
      q <= 1'b1;
    end else begin
      s1_r <= d;
      q <= s1_r;
    end
  end
endmodule

/* File: verif/seep_bench.sv */
`include "seep_consts.svh"
module seep_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, reset = 1, wp = 0, req = 0, tx_start = 0, tx_stop = 0;
  logic [8:0] tx_word = 9'h000;
  logic done, busy;
  logic [8:0] rx_word;
  logic [7:0] rnd = 8'h4d;
  logic [7:0] mdl [128];
  logic [8:0] exp_q [$];
  int errors = 0, compares = 0;
  always #10 clk = ~clk;
  seep_bus_if bus_i ();
  seep_master u_seep_master (.clk(clk), .reset(reset), .req(req),
    .tx_word(tx_word), .tx_start(tx_start), .tx_stop(tx_stop),
    .done(done), .rx_word(rx_word), .bus(bus_i.master));
  seep_device #(.TWC_CYC(200)) u_seep_device (.clk(clk), .reset(reset),
    .wp(wp), .bus(bus_i.device), .busy(busy));
  seep_chk #(.TWC(200)) u_seep_chk (.clk(clk), .reset(reset), .wp(wp),
    .busy(busy), .scl(bus_i.scl), .sda(bus_i.sda),
    .sda_d_o(bus_i.sda_d_o), .sda_d_oe(bus_i.sda_d_oe));
  function automatic logic [7:0] nxt();
    rnd = {rnd[6:0], rnd[7] ^ rnd[5] ^ rnd[4] ^ rnd[3]};
    return rnd;
  endfunction
  // Block bits are random since the device must ignore them
  function automatic logic [7:0] ctl(input logic dir);
    logic [7:0] v;
    v = nxt();
    return {`SEEP_TYPE_CODE, v[3:1], dir};
  endfunction
  task automatic check(input logic [8:0] got, input logic [8:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic results();
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic xfer(input logic [8:0] w, input logic st, input logic sp,
                      input logic [8:0] exp);
    int n;
    exp_q.push_back(exp);
    @(posedge clk);
    req <= 1'b1;
    tx_word <= w;
    tx_start <= st;
    tx_stop <= sp;
    @(posedge clk);
    req <= 1'b0;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (done !== 1'b1 && n < 400);
    if (n >= 400) errors++;
    // Master leaves its done state before the next request
    @(posedge clk);
  endtask
  task automatic snd(input logic [7:0] b, input logic st, input logic sp,
                     input logic ack);
    xfer({b, 1'b1}, st, sp, {b, ack});
  endtask
  task automatic rcv(input logic [7:0] d, input logic last);
    xfer({8'hff, last}, 1'b0, last, {d, last});
  endtask
  task automatic settle();
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 1000) begin
      @(negedge clk);
      n++;
    end
  endtask
  task automatic wr(input logic [6:0] a, input int n);
    logic [7:0] d;
    snd(ctl(`SEEP_DIR_WRITE), 1'b1, 1'b0, 1'b0);
    snd({1'b0, a}, 1'b0, 1'b0, 1'b0);
    for (int i = 0; i < n; i++) begin
      d = nxt();
      if (!wp) mdl[{a[6:3], a[2:0] + i[2:0]}] = d;
      snd(d, 1'b0, i == n - 1, 1'b0);
    end
  endtask
  task automatic poll();
    snd(ctl(`SEEP_DIR_WRITE), 1'b1, 1'b1, 1'b1);
    settle();
    snd(ctl(`SEEP_DIR_WRITE), 1'b1, 1'b1, 1'b0);
  endtask
  task automatic rd(input logic [6:0] a, input int n);
    logic [6:0] p;
    snd(ctl(`SEEP_DIR_WRITE), 1'b1, 1'b0, 1'b0);
    snd({1'b0, a}, 1'b0, 1'b0, 1'b0);
    snd(ctl(`SEEP_DIR_READ), 1'b1, 1'b0, 1'b0);
    for (int i = 0; i < n; i++) begin
      p = a + i[6:0];
      rcv(mdl[p], i == n - 1);
    end
  endtask
  always @(negedge clk) begin
    if (done === 1'b1) check(rx_word, exp_q.pop_front());
  end
  initial begin
    #400000;
    errors++;
    results();
  end
  initial begin
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    wr(7'h00, 2);
    poll();
    wr(7'h7b, 10);
    poll();
    snd({~`SEEP_TYPE_CODE, 4'h4}, 1'b1, 1'b1, 1'b1);
    rd(7'h7e, 3);
    snd(ctl(`SEEP_DIR_READ), 1'b1, 1'b0, 1'b0);
    rcv(mdl[1], 1'b1);
    @(posedge clk);
    wp <= 1'b1;
    wr(7'h00, 1);
    settle();
    rd(7'h00, 1);
    @(posedge clk);
    wp <= 1'b0;
    rd(7'h00, 2);
    results();
  end
endmodule

/* File: verif/seep_chk.sv */
module seep_chk #(
  parameter int TWC = 200
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic wp,
  input wire logic busy,
  input wire logic scl,
  input wire logic sda,
  input wire logic sda_d_o,
  input wire logic sda_d_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  wire logic dpull;
  int cnt_r;
  assign dpull = sda_d_oe & ~sda_d_o;
  always_ff @(posedge clk) begin
    cnt_r <= (reset || !busy) ? 0 : cnt_r + 1;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  busy_no_ack_a: assert property (busy |-> !dpull)
    else $error("device pulled sda while busy");
  dev_hold_a: assert property (scl && $past(scl) |-> $stable(dpull))
    else $error("device moved sda with scl high");
  ack_hold_a: assert property ($rose(scl) && dpull |-> dpull[*7])
    else $error("device pull not held through scl high");
  scl_high_a: assert property ($rose(scl) |-> scl[*8])
    else $error("scl high phase too short");
  ctrl_quiet_a: assert property (scl && $fell(sda) |-> (!dpull)[*8])
    else $error("device drove sda right after start");
  busy_len_a: assert property ($fell(busy) |->
    cnt_r inside {[TWC - 1:TWC + 1]})
    else $error("programming time wrong");
  busy_idle_a: assert property ($rose(busy) |-> scl && sda)
    else $error("programming began without stop");
  wp_guard_a: assert property ($rose(busy) |-> !wp)
    else $error("programming while write protected");
endmodule
